// ### rtl/remote_serial_command_framer.sv
`timescale 1ns/10ps
module remote_serial_command_framer
(
    input  wire logic                        ref_clk,
    input  wire logic                        rstn,
    input  wire framer_pkg::char_fmt_type    char_fmt,
    input  wire logic [15:0]                 bit_cycles,
    input  wire logic [7:0]                  own_station,
    input  wire logic                        rx_pin,
    output logic                             tx_pin,
    output logic                             tx_oe_n,
    output framer_pkg::cmd_char_type         cmd_char,
    input  wire framer_pkg::cmd_result_type  cmd_result,
    input  wire logic                        rsp_valid,
    input  wire logic [7:0]                  rsp_data,
    input  wire logic                        rsp_last,
    output logic                             rsp_ready
);
    import framer_pkg::*;

    typedef enum {
        st_idle,
        st_addr,
        st_body,
        st_skip,
        st_wait,
        st_tx_start,
        st_tx_addr,
        st_tx_slash,
        st_tx_body,
        st_tx_err,
        st_tx_cr,
        st_tx_lf,
        st_tx_end
    } state_type;

    function automatic logic is_digit(input logic [7:0] c);
        is_digit = (c >= CH_ZERO) && (c <= CH_NINE);
    endfunction

    function automatic logic [7:0] err_code(input result_type r);
        case (r)
            bad_parameter_error:       err_code = CODE_BAD_PARAM;
            unknown_command_error:     err_code = CODE_UNKNOWN;
            locked_unit_error:         err_code = CODE_LOCKED;
            unsupported_feature_error: err_code = CODE_UNSUPPORTED;
            hardware_fault_error:      err_code = CODE_HW_FAULT;
            default:                   err_code = CODE_UNKNOWN;
        endcase
    endfunction

    // ==========================================================
    // character serialiser
    // ==========================================================
    logic        rx_valid;
    rx_char_type rx_char;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic        tx_ready;

    char_serdes char_serdes_inst
    (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .fmt        (char_fmt),
        .bit_cycles (bit_cycles),
        .rx_pin     (rx_pin),
        .rx_valid   (rx_valid),
        .rx_char    (rx_char),
        .tx_valid   (tx_valid),
        .tx_data    (tx_data),
        .tx_ready   (tx_ready),
        .tx_pin     (tx_pin),
        .tx_oe_n    (tx_oe_n)
    );

    // ==========================================================
    // state
    // ==========================================================
    state_type   state_q;
    state_type   state_d;
    logic [9:0]  addr_val_q;
    logic [1:0]  addr_len_q;
    logic        addr_star_q;
    logic [7:0]  addr_txt_q [MAX_ADDR_DIG];
    logic [1:0]  tx_idx_q;
    logic [2:0]  err_idx_q;
    logic [5:0]  body_len_q;
    logic        syntax_bad_q;
    logic        global_q;
    result_type  result_q;

    wire [7:0] c          = rx_char.data;
    wire       c_digit    = is_digit(c);
    wire       start_seen = rx_valid && !rx_char.bad && (c == CH_CMD_START);
    wire [9:0] addr_next  = 10'((addr_val_q * 10) + {2'b00, c} - {2'b00, CH_ZERO});
    // zero and asterisk both broadcast, both silent
    wire       addr_global = addr_star_q || (addr_val_q == 10'h000);
    wire       addr_match  = addr_global || (addr_val_q == {2'b00, own_station});
    wire       addr_ok     = addr_star_q || ((addr_len_q != 2'b00) && (addr_val_q <= 10'h0ff));
    wire       addr_end    = rx_valid && !c_digit && !(c == CH_STAR && addr_len_q == 2'b00);
    wire       body_end    = rx_valid && (c == CH_CR);
    wire       body_fault  = rx_char.bad || ((state_q == st_body) && (body_len_q == 6'(MAX_BODY)));
    wire       addr_take   = (state_q == st_addr) && addr_end && addr_ok && addr_match;
    // error text is a fixed "?ERn" followed by the cr lf close
    wire [7:0] err_chars [4] = '{CH_QUERY, CH_E, CH_R, err_code(result_q)};

    assign cmd_char = '{valid:  rx_valid && (state_q == st_body || addr_take) && !body_fault,
                        data:   c,
                        last:   body_end,
                        global: (state_q == st_body) ? global_q : addr_global};
    assign rsp_ready = (state_q == st_tx_body) && tx_ready;

    // ==========================================================
    // sequencing
    // ==========================================================
    always_comb
    begin
        state_d  = state_q;
        tx_valid = 1'b0;
        tx_data  = CH_RSP_END;
        case (state_q)
            st_idle:
                if (start_seen)
                    state_d = st_addr;
            st_addr:
                if (addr_end)
                    state_d = addr_take ? (body_end ? st_wait : st_body) : (body_end ? st_idle : st_skip);
            st_body:
                if (body_end)
                    state_d = st_wait;
            st_skip:
                if (body_end)
                    state_d = st_idle;
            st_wait:
                if (cmd_result.valid || syntax_bad_q)
                    state_d = global_q ? st_idle : st_tx_start;
            st_tx_start:
            begin
                tx_valid = 1'b1;
                tx_data  = CH_RSP_START;
                if (tx_ready)
                    state_d = st_tx_addr;
            end
            st_tx_addr:
            begin
                tx_valid = 1'b1;
                tx_data  = addr_txt_q[tx_idx_q];
                if (tx_ready && tx_idx_q == addr_len_q - 2'b01)
                    state_d = st_tx_slash;
            end
            st_tx_slash:
            begin
                tx_valid = 1'b1;
                tx_data  = CH_SLASH;
                if (tx_ready)
                    state_d = (result_q == status_ok) ? st_tx_body : st_tx_err;
            end
            st_tx_body:
            begin
                tx_valid = rsp_valid;
                tx_data  = rsp_data;
                if (tx_ready && rsp_valid && rsp_last)
                    state_d = st_tx_cr;
            end
            st_tx_err:
            begin
                tx_valid = 1'b1;
                tx_data  = err_chars[err_idx_q[1:0]];
                if (tx_ready && err_idx_q == 3'h3)
                    state_d = st_tx_cr;
            end
            st_tx_cr:
            begin
                tx_valid = 1'b1;
                tx_data  = CH_CR;
                if (tx_ready)
                    state_d = st_tx_lf;
            end
            st_tx_lf:
            begin
                tx_valid = 1'b1;
                tx_data  = CH_LF;
                if (tx_ready)
                    state_d = st_tx_end;
            end
            st_tx_end:
            begin
                tx_valid = 1'b1;
                tx_data  = CH_RSP_END;
                if (tx_ready)
                    state_d = st_idle;
            end
            default:
                state_d = st_idle;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            state_q <= st_idle;
        else
            state_q <= state_d;
    end

    // ==========================================================
    // station field capture
    // ==========================================================
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            addr_val_q  <= 10'h000;
            addr_len_q  <= 2'b00;
            addr_star_q <= 1'b0;
        end
        else if (state_q == st_idle)
        begin
            addr_val_q  <= 10'h000;
            addr_len_q  <= 2'b00;
            addr_star_q <= 1'b0;
        end
        else if (state_q == st_addr && rx_valid && !addr_end)
        begin
            if (c == CH_STAR)
                addr_star_q <= 1'b1;
            else if (addr_len_q == 2'(MAX_ADDR_DIG) || addr_star_q)
                addr_val_q  <= 10'h3ff;
            else
            begin
                addr_val_q <= addr_next;
                addr_len_q <= addr_len_q + 2'b01;
            end
        end
    end

    // echo text kept as received
    always_ff @(posedge ref_clk)
    begin
        if (state_q == st_addr && rx_valid && c_digit && addr_len_q != 2'(MAX_ADDR_DIG))
            addr_txt_q[addr_len_q] <= c;
    end

    // ==========================================================
    // body checks and answer bookkeeping
    // ==========================================================
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            body_len_q   <= 6'h00;
            syntax_bad_q <= 1'b0;
            global_q     <= 1'b0;
            result_q     <= status_ok;
            tx_idx_q     <= 2'b00;
            err_idx_q    <= 3'h0;
        end
        else
        begin
            if (state_q == st_addr && addr_end)
            begin
                global_q     <= addr_global;
                body_len_q   <= {5'h00, !body_end};
                syntax_bad_q <= rx_char.bad;
            end
            if (state_q == st_body && rx_valid && !body_end)
            begin
                if (body_fault)
                    syntax_bad_q <= 1'b1;
                else
                    body_len_q <= body_len_q + 6'h01;
            end
            if (state_q == st_wait)
                result_q <= syntax_bad_q ? unknown_command_error : cmd_result.result;
            if (state_q == st_tx_start)
                tx_idx_q <= 2'b00;
            else if (state_q == st_tx_addr && tx_ready)
                tx_idx_q <= tx_idx_q + 2'b01;
            if (state_q == st_tx_slash)
                err_idx_q <= 3'h0;
            else if (state_q == st_tx_err && tx_ready)
                err_idx_q <= err_idx_q + 3'h1;
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    wire in_rx = (state_q == st_addr) || (state_q == st_body) || (state_q == st_skip);

    no_tx_receiving_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        in_rx |-> tx_oe_n)
        else $error("line driven while receiving");
    tx_only_answer_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_q == st_idle && $past(state_q) == st_idle && tx_ready) |-> !tx_valid)
        else $error("transmit without command");
    global_silent_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_q == st_wait && global_q && cmd_result.valid) |=> state_q == st_idle)
        else $error("answer to broadcast");
    rsp_opens_gt_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_q == st_tx_start) |-> tx_data == CH_RSP_START)
        else $error("answer not opened with gt");
    slash_after_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_q == st_tx_addr && state_d == st_tx_slash) |=> tx_data == CH_SLASH)
        else $error("no slash after station");
    lf_then_end_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_q == st_tx_lf && tx_ready) |=> state_q == st_tx_end && tx_data == CH_RSP_END)
        else $error("answer not closed by bracket");
    syntax_err_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_q == st_wait && syntax_bad_q) |=> result_q == unknown_command_error)
        else $error("syntax fault not reported");
    err_code_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_q == st_tx_err && err_idx_q == 3'h3) |-> tx_data == err_code(result_q))
        else $error("wrong error code");
    addr_range_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_q == st_addr && addr_end && !body_end && !addr_star_q && addr_val_q > 10'h0ff) |=> state_q == st_skip)
        else $error("out of range station accepted");
endmodule

// ### rtl/framer_pkg.sv
package framer_pkg;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned BAUD_DEFAULT  = 9600;
    localparam int unsigned BIT_CYCLES    = 1_000_000_000 / (CLK_PERIOD_NS * BAUD_DEFAULT);
    localparam int unsigned FRAME_BITS    = 11;

    // ==========================================================
    // characters
    // ==========================================================
    localparam logic [7:0] CH_CMD_START  = 8'h3c;
    localparam logic [7:0] CH_RSP_START  = 8'h3e;
    localparam logic [7:0] CH_CR         = 8'h0d;
    localparam logic [7:0] CH_LF         = 8'h0a;
    localparam logic [7:0] CH_RSP_END    = 8'h5d;
    localparam logic [7:0] CH_SLASH      = 8'h2f;
    localparam logic [7:0] CH_STAR       = 8'h2a;
    localparam logic [7:0] CH_QUERY      = 8'h3f;
    localparam logic [7:0] CH_E          = 8'h45;
    localparam logic [7:0] CH_R          = 8'h52;
    localparam logic [7:0] CH_ZERO       = 8'h30;
    localparam logic [7:0] CH_NINE       = 8'h39;
    localparam int unsigned MAX_ADDR_DIG = 3;
    localparam int unsigned MAX_BODY     = 32;

    // ==========================================================
    // character format
    // ==========================================================
    typedef enum logic [1:0] {
        fmt_7odd,
        fmt_7even,
        fmt_8none
    } char_fmt_type;

    // ==========================================================
    // answer codes from the payload decoder
    // ==========================================================
    typedef enum logic [2:0] {
        status_ok,
        bad_parameter_error,
        unknown_command_error,
        locked_unit_error,
        unsupported_feature_error,
        hardware_fault_error
    } result_type;

    localparam logic [7:0] CODE_BAD_PARAM   = 8'h32;
    localparam logic [7:0] CODE_UNKNOWN     = 8'h33;
    localparam logic [7:0] CODE_LOCKED      = 8'h34;
    localparam logic [7:0] CODE_UNSUPPORTED = 8'h35;
    localparam logic [7:0] CODE_HW_FAULT    = 8'h39;

    typedef struct packed {
        logic [7:0] data;
        logic       bad;
    } rx_char_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       last;
        logic       global;
    } cmd_char_type;

    typedef struct packed {
        logic       valid;
        result_type result;
    } cmd_result_type;

endpackage

// ### rtl/char_serdes.sv
`timescale 1ns/10ps
module char_serdes
(
    input  wire logic                       ref_clk,
    input  wire logic                       rstn,
    input  wire framer_pkg::char_fmt_type   fmt,
    input  wire logic [15:0]                bit_cycles,
    input  wire logic                       rx_pin,
    output logic                            rx_valid,
    output framer_pkg::rx_char_type         rx_char,
    input  wire logic                       tx_valid,
    input  wire logic [7:0]                 tx_data,
    output logic                            tx_ready,
    output logic                            tx_pin,
    output logic                            tx_oe_n
);
    import framer_pkg::*;

    // ==========================================================
    // pin synchroniser
    // ==========================================================
    logic        rx_meta_q;
    logic        rx_sync_q;
    always_ff @(posedge ref_clk)
    begin
        rx_meta_q <= rstn ? rx_pin : 1'b1;
        rx_sync_q <= rstn ? rx_meta_q : 1'b1;
    end

    function automatic logic par_bit(input logic [7:0] d, input char_fmt_type f);
        par_bit = (f == fmt_7odd) ? ~(^d[6:0]) : (^d[6:0]);
    endfunction

    // ==========================================================
    // receiver: 11 bit frames, sampled mid bit
    // ==========================================================
    logic [15:0] rx_cnt_q;
    logic [3:0]  rx_bit_q;
    logic [10:0] rx_sh_q;
    logic        rx_busy_q;
    logic        rx_vld_q;
    rx_char_type rx_out_q;
    wire         rx_tick   = rx_busy_q && (rx_cnt_q == 16'h0000);
    wire         rx_done   = rx_tick && (rx_bit_q == 4'(FRAME_BITS - 1));
    wire  [10:0] rx_full   = {rx_sync_q, rx_sh_q[10:1]};
    wire         rx_par_ok = (fmt == fmt_8none) || (rx_full[8] == par_bit(rx_full[8:1], fmt));
    wire         rx_bad    = !rx_par_ok || !rx_full[10] || ((fmt == fmt_8none) && !rx_full[9]);
    wire  [7:0]  rx_byte   = (fmt == fmt_8none) ? rx_full[8:1] : {1'b0, rx_full[7:1]};

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            rx_busy_q <= 1'b0;
            rx_cnt_q  <= 16'h0000;
            rx_bit_q  <= 4'h0;
            rx_sh_q   <= 11'h7ff;
            rx_vld_q  <= 1'b0;
            rx_out_q  <= '0;
        end
        else
        begin
            rx_vld_q <= rx_done;
            if (rx_done)
                rx_out_q <= '{data: rx_byte, bad: rx_bad};
            if (!rx_busy_q && !rx_sync_q)
            begin
                rx_busy_q <= 1'b1;
                rx_bit_q  <= 4'h0;
                rx_cnt_q  <= {1'b0, bit_cycles[15:1]};
            end
            else if (rx_tick)
            begin
                rx_sh_q  <= rx_full;
                rx_cnt_q <= bit_cycles - 16'h0001;
                rx_bit_q <= rx_bit_q + 4'h1;
                if (rx_done || (rx_bit_q == 4'h0 && rx_sync_q))
                    rx_busy_q <= 1'b0;
            end
            else if (rx_busy_q)
                rx_cnt_q <= rx_cnt_q - 16'h0001;
        end
    end
    assign rx_valid = rx_vld_q;
    assign rx_char  = rx_out_q;

    // ==========================================================
    // transmitter: drives the line only while a frame is out
    // ==========================================================
    logic [15:0] tx_cnt_q;
    logic [3:0]  tx_bit_q;
    logic [10:0] tx_sh_q;
    logic        tx_busy_q;
    wire  [10:0] tx_frame = (fmt == fmt_8none) ? {2'b11, tx_data, 1'b0}
                          : {2'b11, par_bit(tx_data, fmt), tx_data[6:0], 1'b0};
    assign tx_ready = !tx_busy_q;

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            tx_busy_q <= 1'b0;
            tx_cnt_q  <= 16'h0000;
            tx_bit_q  <= 4'h0;
            tx_sh_q   <= 11'h7ff;
        end
        else if (!tx_busy_q && tx_valid)
        begin
            tx_busy_q <= 1'b1;
            tx_sh_q   <= tx_frame;
            tx_cnt_q  <= bit_cycles - 16'h0001;
            tx_bit_q  <= 4'h0;
        end
        else if (tx_busy_q && tx_cnt_q == 16'h0000)
        begin
            tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
            tx_cnt_q <= bit_cycles - 16'h0001;
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == 4'(FRAME_BITS - 1))
                tx_busy_q <= 1'b0;
        end
        else if (tx_busy_q)
            tx_cnt_q <= tx_cnt_q - 16'h0001;
    end
    assign tx_pin  = tx_busy_q ? tx_sh_q[0] : 1'b1;
    assign tx_oe_n = !tx_busy_q;
endmodule

// ### tb/serial_terminal.sv
`timescale 1ns/10ps
module serial_terminal
    import framer_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire char_fmt_type fmt,
    input  wire logic [15:0]  bit_cycles,
    input  wire logic         tx_pin,
    input  wire logic         tx_oe_n,
    output logic              rx_pin,
    output logic              got_valid,
    output logic [7:0]        got_data
);
    logic [10:0] rf;
    logic [7:0]  rd;

    // ==========================================================
    // character framing
    // ==========================================================
    function automatic logic [10:0] frame(input logic [7:0] c);
        if (fmt == fmt_8none)
            return {2'b11, c, 1'b0};
        return {2'b11, ^c[6:0] ^ (fmt == fmt_7odd), c[6:0], 1'b0};
    endfunction

    task automatic send_char(input logic [7:0] c);
        logic [10:0] f;
        f = frame(c);
        for (int i = 0; i < 11; i++)
        begin
            rx_pin = f[i];
            repeat (bit_cycles) @(negedge ref_clk);
        end
    endtask

    task automatic send_cmd(input string s);
        send_char(CH_CMD_START);
        foreach (s[i]) send_char(s[i]);
        send_char(CH_CR);
    endtask

    // ==========================================================
    // answer receiver
    // ==========================================================
    // a badly framed char is handed on as ff so the bench flags it
    initial
    begin
        rx_pin    = 1'b1;
        got_valid = 1'b0;
        got_data  = 8'h00;
        forever
        begin
            @(posedge ref_clk);
            if (tx_oe_n === 1'b0 && tx_pin === 1'b0)
            begin
                repeat (bit_cycles / 2) @(posedge ref_clk);
                rf[0] = 1'b0;
                for (int i = 1; i < 11; i++)
                begin
                    repeat (bit_cycles) @(posedge ref_clk);
                    rf[i] = tx_pin;
                end
                rd = fmt == fmt_8none ? rf[8:1] : {1'b0, rf[7:1]};
                got_data <= rf === frame(rd) ? rd : 8'hff;
                got_valid <= 1'b1;
                @(posedge ref_clk);
                got_valid <= 1'b0;
            end
        end
    end
endmodule

// ### tb/remote_serial_command_framer_tb.sv
`timescale 1ns/10ps
module remote_serial_command_framer_tb;
    import framer_pkg::*;
    logic           ref_clk = 1'b0;
    logic           rstn = 1'b0;
    char_fmt_type   char_fmt = fmt_8none;
    logic [15:0]    bit_cycles = 16'h0008;
    logic [7:0]     own_station = 8'h05;
    logic           rx_pin;
    logic           tx_pin;
    logic           tx_oe_n;
    cmd_char_type   cmd_char;
    cmd_result_type cmd_result = '0;
    logic           rsp_valid = 1'b0;
    logic [7:0]     rsp_data = 8'h00;
    logic           rsp_last = 1'b0;
    logic           rsp_ready;
    logic           got_valid;
    logic [7:0]     got_data;
    int             mismatches = 0;
    int             tests_run = 0;
    int             seed = 19;
    logic [7:0]     ans_q[$];
    logic [9:0]     cmd_q[$];
    logic [7:0]     txt_q[$];
    logic [7:0]     codes[6] = '{8'h00, CODE_BAD_PARAM, CODE_UNKNOWN, CODE_LOCKED, CODE_UNSUPPORTED, CODE_HW_FAULT};

    always #5 ref_clk = ~ref_clk;

    remote_serial_command_framer remote_serial_command_framer_inst (.ref_clk(ref_clk), .rstn(rstn),
        .char_fmt(char_fmt), .bit_cycles(bit_cycles), .own_station(own_station), .rx_pin(rx_pin),
        .tx_pin(tx_pin), .tx_oe_n(tx_oe_n), .cmd_char(cmd_char), .cmd_result(cmd_result),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready));
    serial_terminal serial_terminal_inst (.ref_clk(ref_clk), .fmt(char_fmt), .bit_cycles(bit_cycles),
        .tx_pin(tx_pin), .tx_oe_n(tx_oe_n), .rx_pin(rx_pin), .got_valid(got_valid), .got_data(got_data));

    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ==========================================================
    // payload decoder stand-in and monitors
    // ==========================================================
    // result held as a level until the next command, so a late wait state cannot miss it
    always @(negedge ref_clk)
    begin
        if (cmd_char.valid === 1'b1 && cmd_char.last === 1'b1)
            cmd_result.valid <= 1'b1;
        rsp_valid <= txt_q.size() != 0;
        rsp_data <= txt_q.size() != 0 ? txt_q[0] : 8'h00;
        rsp_last <= txt_q.size() == 1;
    end

    always @(posedge ref_clk)
    begin
        if (rsp_valid && rsp_ready === 1'b1)
            void'(txt_q.pop_front());
        if (got_valid === 1'b1)
            check("answer char", {2'b00, got_data},
                  ans_q.size() ? {2'b00, ans_q.pop_front()} : 10'h3ff);
        if (cmd_char.valid === 1'b1)
            check("body char", {cmd_char.data, cmd_char.last, cmd_char.global},
                  cmd_q.size() ? cmd_q.pop_front() : 10'h3ff);
    end

    // ==========================================================
    // one command with its expected answer
    // ==========================================================
    task automatic run_cmd(input string stn, input result_type res, input bit answered, input bit taken,
                           input int len = 1);
        logic [7:0] body;
        logic [7:0] txt;
        logic       glb;
        string      s;
        int         n;
        result_type er;
        body = 8'h41 + 8'({$random(seed)} % 26);
        txt = 8'h61 + 8'({$random(seed)} % 26);
        glb = stn == "0" || stn == "*";
        // an overlong body is a syntax fault whatever the decoder answers
        er = len > MAX_BODY ? unknown_command_error : res;
        s = stn;
        repeat (len) s = {s, " "};
        for (int i = stn.len(); i < s.len(); i++)
            s[i] = body;
        @(negedge ref_clk);
        cmd_result.valid <= 1'b0;
        cmd_result.result <= res;
        if (taken)
            for (int i = 0; i <= len; i++)
                if (len <= MAX_BODY || i < MAX_BODY)
                    cmd_q.push_back(i == len ? {CH_CR, 1'b1, glb} : {body, 1'b0, glb});
        if (answered)
        begin
            ans_q.push_back(CH_RSP_START);
            foreach (stn[i]) ans_q.push_back(stn[i]);
            ans_q.push_back(CH_SLASH);
            if (er == status_ok)
            begin
                txt_q.push_back(txt);
                ans_q.push_back(txt);
            end
            else
            begin
                ans_q.push_back(CH_QUERY);
                ans_q.push_back(CH_E);
                ans_q.push_back(CH_R);
                ans_q.push_back(codes[er]);
            end
            ans_q.push_back(CH_CR);
            ans_q.push_back(CH_LF);
            ans_q.push_back(CH_RSP_END);
        end
        serial_terminal_inst.send_cmd(s);
        n = 0;
        while ((ans_q.size() || cmd_q.size() || tx_oe_n !== 1'b1) && n < 4000)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 4000)
            mismatches++;
        // window long enough for any stray answer to show
        repeat (300) @(negedge ref_clk);
    endtask

    initial
    begin
        for (int f = 0; f < 3; f++)
        begin
            @(negedge ref_clk);
            rstn = 1'b0;
            char_fmt = char_fmt_type'(f);
            repeat (3) @(negedge ref_clk);
            rstn = 1'b1;
            repeat (3) @(negedge ref_clk);
            run_cmd("5", status_ok, 1'b1, 1'b1);
        end
        for (int r = 1; r < 6; r++)
            run_cmd("5", result_type'(r), 1'b1, 1'b1);
        run_cmd("5", bad_parameter_error, 1'b1, 1'b1, MAX_BODY + 1);
        run_cmd("0", status_ok, 1'b0, 1'b1);
        run_cmd("*", status_ok, 1'b0, 1'b1);
        run_cmd("7", status_ok, 1'b0, 1'b0);
        run_cmd("256", status_ok, 1'b0, 1'b0);
        @(negedge ref_clk);
        own_station = 8'hff;
        run_cmd("255", status_ok, 1'b1, 1'b1);
        report_and_stop;
    end
endmodule
